/* File: rtl/tms_consts.svh */
// constants of the temperature and voltage monitor sequencer
// assumes a 250 MHz core clock and an 8-bit register port
`ifndef TMS_CONSTS_SVH
`define TMS_CONSTS_SVH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define TMS_CLK_HZ        250000000
`define TMS_OSC_HZ        22500
`define TMS_TICK_CYCLES   (`TMS_CLK_HZ / `TMS_OSC_HZ)
`define TMS_CONV_US       711
`define TMS_REMOTE_US     2130
`define TMS_CONV_TICKS    ((`TMS_CONV_US * `TMS_OSC_HZ + 999999) / 1000000)
`define TMS_REMOTE_TICKS  ((`TMS_REMOTE_US * `TMS_OSC_HZ + 999999) / 1000000)
`define TMS_SAMPLES       16
// ---------------------------------------------------------------
// channels in visiting order
// ---------------------------------------------------------------
`define TMS_NUM_CH        21
`define TMS_CH_REMOTE1    5'h00
`define TMS_CH_REMOTE2    5'h01
`define TMS_CH_AIN_A      5'h0F
`define TMS_CH_AIN_B      5'h10
`define TMS_CH_LOCAL      5'h13
`define TMS_CH_BATTERY    5'h14
// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define TMS_CFG_ADDR      8'h00
`define TMS_SEQ_ADDR      8'h02
`define TMS_STAT_ADDR     8'h08
`define TMS_MASK_ADDR     8'h0C
`define TMS_LOCAL_ADDR    8'h1F
`define TMS_PAIR_A_ADDR   8'h27
`define TMS_PAIR_B_ADDR   8'h29
`define TMS_HI_PAGE       3'h2
`define TMS_LO_PAGE       3'h3
`define TMS_VAL_PAGE      3'h4
`define TMS_CFG_START     0
`define TMS_CFG_INT_EN    1
`define TMS_CFG_INT_CLR   2
`define TMS_CFG_ANALOG    3
`define TMS_CFG_RESET     8'h00
`define TMS_VOLT_HI_RESET 8'hFF
`define TMS_VOLT_LO_RESET 8'h00
`define TMS_TEMP_HI_RESET 8'h7F
`define TMS_TEMP_LO_RESET 8'h80
`endif

/* File: rtl/tms_pkg.sv */
// types of the temperature and voltage monitor sequencer
// assumes tms_consts.svh supplies the numbers
package tms_pkg;
   // sequencer states, one-hot
   typedef enum logic [2:0] {
      TMS_IDLE  = 3'b001,
      TMS_CONV  = 3'b010,
      TMS_STORE = 3'b100
   } tms_state_t;
   typedef logic [7:0] tms_byte_t;
endpackage : tms_pkg

/* File: rtl/tms_sequencer.sv */
// round-robin monitor sequencer with averaging, limits, interrupt
// assumes converter data on core_clk_in, valid at window end
// What this block does
// - local sensor result stored at 1Fh as twos complement
// - temperatures are 8-bit twos complement, one degree per step
// - config bit 3 picks diode (0) or two analog inputs (1)
// - each channel but the battery converted sixteen times and averaged
// - conversion lasts 711 us, remote channels 2.13 ms
// - voltage above high or below low limit raises interrupt
// - temperature alarm sets above hot limit, clears at low
// - start bit 0, when set, begins converting, whatever the clear bit
// - interrupt output only while enable bit 1 is set
// - visit remote one first, battery last, store each kept result
// - repeat until start cleared; results readable any time
// - shared pair converted as analog and as diode every cycle
// - analog mode fills 27h and 29h; diode mode fills 29h
// - cycle covers supplies, analog inputs, 3.3 V and temps
// - timing counts ticks of an internal 22.5 kHz clock
// - battery channel converted once without averaging
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "tms_consts.svh"
module tms_sequencer
   import tms_pkg::*;
#(
   parameter int TICK_CYCLES = `TMS_TICK_CYCLES
) (
   // clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       reset_n_in,
   // register port
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out,
   // converter front end
   output logic      [4:0] adc_chan_out,
   output logic            adc_busy_out,
   input  wire logic [7:0] adc_data_in,
   output logic            pair_diode_mode_out,
   // interrupt
   output logic            int_out
);
   localparam int N = `TMS_NUM_CH;
   localparam logic [5:0] CONV_LAST = 6'(`TMS_CONV_TICKS - 1);
   localparam logic [5:0] REM_LAST = 6'(`TMS_REMOTE_TICKS - 1);
   localparam logic [3:0] SAMP_LAST = 4'(`TMS_SAMPLES - 1);

   tms_state_t  state_reg;
   logic [13:0] osc_cnt_reg;
   logic        osc_tick;
   logic [5:0]  tick_cnt_reg;
   logic [3:0]  samp_cnt_reg;
   logic [4:0]  chan_reg;
   logic [11:0] acc_reg;
   logic [7:0]  cfg_reg;
   tms_byte_t   value_reg [N];
   tms_byte_t   hi_reg [N];
   tms_byte_t   lo_reg [N];
   logic [N-1:0] alarm_reg;
   logic [23:0] status_reg;
   logic [23:0] mask_reg;
   logic [23:0] status_next;
   logic [23:0] ev;
   logic [23:0] w1c;
   logic [7:0]  rdata_next;
   logic [7:0]  reg_rdata_reg;
   logic        is_temp;
   logic        is_remote;
   logic        is_batt;
   logic        conv_done;
   logic        last_samp;
   logic        discard;
   logic        store_en;
   logic [11:0] samp_ext;
   logic [7:0]  store_val;
   logic        hot;
   logic        cool;
   logic        over;
   logic        under;
   logic [4:0]  idx;
   logic        idx_ok;

   // ---------------------------------------------------------------
   // internal oscillator tick
   // ---------------------------------------------------------------
   // free-running divider standing in for the 22.5 kHz clock
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         osc_cnt_reg <= 14'h0000;
      end else if (osc_tick) begin
         osc_cnt_reg <= 14'h0000;
      end else begin
         osc_cnt_reg <= osc_cnt_reg + 14'h0001;
      end
   end
   assign osc_tick = (osc_cnt_reg == 14'(TICK_CYCLES - 1));

   // ---------------------------------------------------------------
   // channel decode
   // ---------------------------------------------------------------
   // remote one and two first, then local and battery last in the visiting order
   assign is_remote = (chan_reg == `TMS_CH_REMOTE1) ||
                      (chan_reg == `TMS_CH_REMOTE2);
   assign is_temp   = is_remote || (chan_reg == `TMS_CH_LOCAL);
   assign is_batt   = (chan_reg == `TMS_CH_BATTERY);
   // remote diodes need three times the window of the others
   assign conv_done = (state_reg == TMS_CONV) && osc_tick &&
                      (tick_cnt_reg == (is_remote ? REM_LAST : CONV_LAST));
   assign last_samp = conv_done && (is_batt || samp_cnt_reg == SAMP_LAST);
   // temperatures sign extend so the sum stays twos complement
   assign samp_ext  = is_temp ? {{4{adc_data_in[7]}}, adc_data_in}
                              : {4'h0, adc_data_in};
   // battery holds one unaveraged sample in the low byte
   assign store_val = is_batt ? acc_reg[7:0] : acc_reg[11:4];
   // both readings of the shared pair are taken, one is dropped
   assign discard = cfg_reg[`TMS_CFG_ANALOG] ?
                    (chan_reg == `TMS_CH_REMOTE2) :
                    ((chan_reg == `TMS_CH_AIN_A) ||
                     (chan_reg == `TMS_CH_AIN_B));
   assign store_en = (state_reg == TMS_STORE) && !discard;
   assign pair_diode_mode_out = !cfg_reg[`TMS_CFG_ANALOG];
   assign adc_chan_out = chan_reg;
   assign adc_busy_out = (state_reg == TMS_CONV);

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   // stopping aborts the running group; restart begins at remote one
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= TMS_IDLE;
      end else begin
         unique case (state_reg)
            TMS_IDLE: begin
               if (cfg_reg[`TMS_CFG_START]) begin
                  state_reg <= TMS_CONV;
               end
            end
            TMS_CONV: begin
               if (!cfg_reg[`TMS_CFG_START]) begin
                  state_reg <= TMS_IDLE;
               end else if (last_samp) begin
                  state_reg <= TMS_STORE;
               end
            end
            TMS_STORE: begin
               state_reg <= cfg_reg[`TMS_CFG_START] ? TMS_CONV : TMS_IDLE;
            end
            default: begin
               state_reg <= TMS_IDLE;
            end
         endcase
      end
   end

   // channel pointer wraps after local and battery
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         chan_reg <= 5'h00;
      end else if (state_reg == TMS_IDLE) begin
         chan_reg <= `TMS_CH_REMOTE1;
      end else if (state_reg == TMS_STORE) begin
         chan_reg <= (chan_reg == 5'(N - 1)) ? 5'h00 : chan_reg + 5'h01;
      end
   end

   // tick count within one conversion window
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tick_cnt_reg <= 6'h00;
      end else if (state_reg != TMS_CONV || conv_done) begin
         tick_cnt_reg <= 6'h00;
      end else if (osc_tick) begin
         tick_cnt_reg <= tick_cnt_reg + 6'h01;
      end
   end

   // sample count and accumulator restart with each group
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         samp_cnt_reg <= 4'h0;
         acc_reg      <= 12'h000;
      end else if (state_reg != TMS_CONV) begin
         samp_cnt_reg <= 4'h0;
         acc_reg      <= 12'h000;
      end else if (conv_done) begin
         samp_cnt_reg <= samp_cnt_reg + 4'h1;
         acc_reg      <= acc_reg + samp_ext;
      end
   end

   // ---------------------------------------------------------------
   // results and limits
   // ---------------------------------------------------------------
   // whole byte lands in one edge, so no read sees half a result
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < N; i++) begin
            value_reg[i] <= 8'h00;
         end
      end else if (store_en) begin
         value_reg[chan_reg] <= store_val;
      end
   end

   assign hot   = $signed(store_val) > $signed(hi_reg[chan_reg]);
   assign cool  = $signed(store_val) <= $signed(lo_reg[chan_reg]);
   assign over  = store_val > hi_reg[chan_reg];
   assign under = store_val < lo_reg[chan_reg];

   // one event per new alarm or per out-of-window reading
   always_comb begin
      ev = 24'h000000;
      if (store_en) begin
         ev[chan_reg] = is_temp ? (hot && !alarm_reg[chan_reg])
                                : (over || under);
      end
   end

   // temperature alarm level with hysteresis
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         alarm_reg <= '0;
      end else if (store_en && is_temp) begin
         if (hot) begin
            alarm_reg[chan_reg] <= 1'b1;
         end else if (cool) begin
            alarm_reg[chan_reg] <= 1'b0;
         end
      end
   end

   // limit pages share one 5-bit index
   assign idx    = reg_addr_in[4:0];
   assign idx_ok = (idx < 5'(N));

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < N; i++) begin
            if (i == 0 || i == 1 || i == 19) begin
               hi_reg[i] <= `TMS_TEMP_HI_RESET;
               lo_reg[i] <= `TMS_TEMP_LO_RESET;
            end else begin
               hi_reg[i] <= `TMS_VOLT_HI_RESET;
               lo_reg[i] <= `TMS_VOLT_LO_RESET;
            end
         end
      end else if (reg_wr_in && idx_ok) begin
         if (reg_addr_in[7:5] == `TMS_HI_PAGE) begin
            hi_reg[idx] <= reg_wdata_in;
         end
         if (reg_addr_in[7:5] == `TMS_LO_PAGE) begin
            lo_reg[idx] <= reg_wdata_in;
         end
      end
   end

   // ---------------------------------------------------------------
   // configuration, status, mask
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cfg_reg <= `TMS_CFG_RESET;
      end else if (reg_wr_in && reg_addr_in == `TMS_CFG_ADDR) begin
         cfg_reg <= reg_wdata_in;
      end
   end

   // write-one-to-clear bytes; a same-cycle event still sets
   always_comb begin
      w1c = 24'h000000;
      if (reg_wr_in) begin
         for (int b = 0; b < 3; b++) begin
            if (reg_addr_in == `TMS_STAT_ADDR + 8'(b)) begin
               w1c[b*8 +: 8] = reg_wdata_in;
            end
         end
      end
      status_next = (status_reg & ~w1c) | ev;
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         status_reg <= 24'h000000;
      end else begin
         status_reg <= status_next;
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mask_reg <= 24'h000000;
      end else if (reg_wr_in) begin
         for (int b = 0; b < 3; b++) begin
            if (reg_addr_in == `TMS_MASK_ADDR + 8'(b)) begin
               mask_reg[b*8 +: 8] <= reg_wdata_in;
            end
         end
      end
   end

   // clear bit holds the pin quiet without losing pending status
   assign int_out = cfg_reg[`TMS_CFG_INT_EN] && !cfg_reg[`TMS_CFG_INT_CLR] &&
                    |(status_reg & mask_reg);

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   always_comb begin
      rdata_next = 8'h00;
      if (reg_addr_in == `TMS_CFG_ADDR) begin
         rdata_next = cfg_reg;
      end else if (reg_addr_in == `TMS_SEQ_ADDR) begin
         rdata_next = {adc_busy_out, 2'h0, chan_reg};
      end else if (reg_addr_in == `TMS_LOCAL_ADDR) begin
         rdata_next = value_reg[`TMS_CH_LOCAL];
      end else if (reg_addr_in == `TMS_PAIR_A_ADDR) begin
         rdata_next = value_reg[`TMS_CH_AIN_A];
      end else if (reg_addr_in == `TMS_PAIR_B_ADDR) begin
         rdata_next = cfg_reg[`TMS_CFG_ANALOG] ? value_reg[`TMS_CH_AIN_B]
                                               : value_reg[`TMS_CH_REMOTE2];
      end else if (reg_addr_in[7:5] == `TMS_VAL_PAGE && idx_ok) begin
         rdata_next = value_reg[idx];
      end else if (reg_addr_in[7:5] == `TMS_HI_PAGE && idx_ok) begin
         rdata_next = hi_reg[idx];
      end else if (reg_addr_in[7:5] == `TMS_LO_PAGE && idx_ok) begin
         rdata_next = lo_reg[idx];
      end else begin
         for (int b = 0; b < 3; b++) begin
            if (reg_addr_in == `TMS_STAT_ADDR + 8'(b)) begin
               rdata_next = status_reg[b*8 +: 8];
            end
            if (reg_addr_in == `TMS_MASK_ADDR + 8'(b)) begin
               rdata_next = mask_reg[b*8 +: 8];
            end
         end
      end
   end

   // data only in the cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         reg_rdata_reg <= 8'h00;
      end else begin
         reg_rdata_reg <= reg_rd_in ? rdata_next : 8'h00;
      end
   end
   assign reg_rdata_out = reg_rdata_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);

   // results and ordering
   local_store_a: assert property (
      store_en && chan_reg == `TMS_CH_LOCAL |=>
         value_reg[`TMS_CH_LOCAL] == $past(acc_reg[11:4]))
      else $error("local result not stored from average");
   local_read_a: assert property (
      reg_rd_in && reg_addr_in == `TMS_LOCAL_ADDR |=>
         reg_rdata_out == $past(value_reg[`TMS_CH_LOCAL]))
      else $error("local read returned wrong byte");
   wrap_order_a: assert property (
      state_reg == TMS_STORE && chan_reg == 5'(N - 1) &&
      cfg_reg[`TMS_CFG_START] |=> chan_reg == `TMS_CH_REMOTE1 &&
      state_reg == TMS_CONV)
      else $error("cycle did not restart at remote one");
   stop_seq_a: assert property (
      !cfg_reg[`TMS_CFG_START] |=> state_reg == TMS_IDLE)
      else $error("sequencer kept running after stop");
   // the pin stays quiet whenever enable is off or clear is held
   int_gate_a: assert property (
      !cfg_reg[`TMS_CFG_INT_EN] || cfg_reg[`TMS_CFG_INT_CLR] |-> !int_out)
      else $error("interrupt driven while disabled");

   // averaging
   sixteen_avg_a: assert property (
      $rose(state_reg == TMS_STORE) && !is_batt |->
         $past(samp_cnt_reg) == SAMP_LAST)
      else $error("group stored after wrong sample count");
   batt_single_a: assert property (
      $rose(state_reg == TMS_STORE) && is_batt |->
         $past(samp_cnt_reg) == 4'h0)
      else $error("battery averaged");
   pair_drop_a: assert property (
      state_reg == TMS_STORE && chan_reg == `TMS_CH_REMOTE2 &&
      cfg_reg[`TMS_CFG_ANALOG] |=>
         $stable(value_reg[`TMS_CH_REMOTE2]))
      else $error("diode result kept in analog mode");

   // limits
   volt_event_a: assert property (
      store_en && !is_temp && (over || under) |=>
         status_reg[$past(chan_reg)])
      else $error("limit breach set no status");
   temp_alarm_a: assert property (
      store_en && is_temp && hot |=> alarm_reg[$past(chan_reg)])
      else $error("hot limit did not raise alarm");
endmodule : tms_sequencer

/* File: tb/test_tms_sequencer.sv */
// self-checking bench of the monitor sequencer over its register port
// assumes the converter model in tms_adc_model and a shortened tick
`timescale 1ns/1ps
`include "tms_consts.svh"
module test_tms_sequencer
   import tms_pkg::*;
;
   localparam int TICK = 4;
   logic       core_clk_in = 1'b0;
   logic       reset_n_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic       reg_wr_in = 1'b0;
   logic       reg_rd_in = 1'b0;
   logic [7:0] reg_rdata_out;
   logic [4:0] adc_chan_out;
   logic       adc_busy_out;
   logic [7:0] adc_data_in;
   logic       pair_diode_mode_out;
   logic       int_out;
   int         num_errors = 0;
   int         compares = 0;
   logic       stopping = 1'b0;
   logic       last_busy = 1'b0;
   logic [4:0] last_chan = 5'h00;
   int         busy_cnt = 0;
   int         glen;

   // ---------------------------------------------------------------
   // clock, design and converter
   // ---------------------------------------------------------------
   always #2 core_clk_in = ~core_clk_in;

   tms_sequencer #(.TICK_CYCLES(TICK)) i_tms_sequencer (
      .core_clk_in         (core_clk_in),
      .reset_n_in          (reset_n_in),
      .reg_addr_in         (reg_addr_in),
      .reg_wdata_in        (reg_wdata_in),
      .reg_wr_in           (reg_wr_in),
      .reg_rd_in           (reg_rd_in),
      .reg_rdata_out       (reg_rdata_out),
      .adc_chan_out        (adc_chan_out),
      .adc_busy_out        (adc_busy_out),
      .adc_data_in         (adc_data_in),
      .pair_diode_mode_out (pair_diode_mode_out),
      .int_out             (int_out)
   );

   tms_adc_model #(.TICK_CYCLES(TICK)) i_tms_adc_model (
      .core_clk_in         (core_clk_in),
      .reset_n_in          (reset_n_in),
      .adc_chan_out        (adc_chan_out),
      .adc_busy_out        (adc_busy_out),
      .pair_diode_mode_out (pair_diode_mode_out),
      .adc_data_in         (adc_data_in)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input string what, input tms_byte_t exp, input tms_byte_t got);
      compares++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask : chk

   task automatic wr(input tms_byte_t a, input tms_byte_t d);
      @(posedge core_clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
      #1;
   endtask : wr

   // read data is taken in the cycle after the strobe, its only cycle
   task automatic rd_chk(input string what, input tms_byte_t a, input tms_byte_t exp);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1;
      chk(what, exp, reg_rdata_out);
   endtask : rd_chk

   // bounded wait for a group of the given channel to be running
   task automatic wait_chan(input logic [4:0] c);
      int n;
      n = 0;
      while ((adc_chan_out !== c || adc_busy_out !== 1'b1) && n < 30000) begin
         @(posedge core_clk_in);
         #1;
         n++;
      end
      chk("channel reached", {3'h0, c}, {3'h0, adc_chan_out});
   endtask : wait_chan

   task automatic run_cycle;
      wait_chan(5'h14);
      wait_chan(5'h00);
   endtask : run_cycle

   function automatic tms_byte_t exp_val(input int n);
      case (n)
         0:       return 8'hE7;
         1:       return 8'h19;
         19:      return 8'h9C;
         20:      return 8'h55;
         default: return 8'h20 + n[7:0];
      endcase
   endfunction : exp_val

   task automatic conclude;
      if (num_errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   // ---------------------------------------------------------------
   // visiting order and group length, skipped around a deliberate stop
   // ---------------------------------------------------------------
   always @(posedge core_clk_in) begin
      if (reset_n_in && adc_chan_out !== last_chan && !stopping) begin
         chk("next channel", (last_chan == 5'h14) ? 8'h00 : {3'h0, last_chan} + 8'h01,
             {3'h0, adc_chan_out});
      end
      if (last_busy && adc_busy_out !== 1'b1 && !stopping) begin
         glen = ((last_chan == 5'h14) ? 1 : 16) * ((last_chan < 5'h02) ? 48 : 16) * TICK;
         compares++;
         if (busy_cnt > glen + 2 || busy_cnt + 2 * TICK < glen) begin
            $display("Error group length expected %0d seen %0d", glen, busy_cnt);
            num_errors++;
         end
      end
      busy_cnt  = (adc_busy_out === 1'b1) ? busy_cnt + 1 : 0;
      last_busy = (adc_busy_out === 1'b1);
      last_chan = adc_chan_out;
   end

   // ---------------------------------------------------------------
   // watchdog: three monitoring cycles take about 75000 clocks
   // ---------------------------------------------------------------
   initial begin
      #360000;
      num_errors++;
      conclude();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      #1;
      chk("int after reset", 8'h00, {7'h00, int_out});
      chk("pair diode mode", 8'h01, {7'h00, pair_diode_mode_out});
      rd_chk("config", `TMS_CFG_ADDR, `TMS_CFG_RESET);
      rd_chk("unmapped", 8'hF0, 8'h00);
      rd_chk("temp high", 8'h40, `TMS_TEMP_HI_RESET);
      // read data stands one cycle only, then returns to zero
      @(posedge core_clk_in);
      #1;
      chk("read data idle", 8'h00, reg_rdata_out);
      rd_chk("temp low", 8'h60, `TMS_TEMP_LO_RESET);
      rd_chk("volt high", 8'h42, `TMS_VOLT_HI_RESET);
      rd_chk("volt low", 8'h62, `TMS_VOLT_LO_RESET);
      // trip remote one hot, channel 3 high and channel 5 low
      wr(8'h40, 8'hE0);
      wr(8'h43, 8'h10);
      wr(8'h65, 8'hF0);
      wr(`TMS_MASK_ADDR, 8'h09);
      wr(`TMS_CFG_ADDR, 8'h03);
      run_cycle();
      for (int n = 0; n < 21; n++) begin
         if (n != 15 && n != 16) begin
            rd_chk("value", 8'h80 + n[7:0], exp_val(n));
         end
      end
      rd_chk("local temp", `TMS_LOCAL_ADDR, 8'h9C);
      rd_chk("pair temp", `TMS_PAIR_B_ADDR, 8'h19);
      rd_chk("status", `TMS_STAT_ADDR, 8'h29);
      rd_chk("status top", 8'h0A, 8'h00);
      chk("int raised", 8'h01, {7'h00, int_out});
      wr(`TMS_MASK_ADDR, 8'h00);
      chk("int masked", 8'h00, {7'h00, int_out});
      wr(`TMS_MASK_ADDR, 8'h09);
      wr(`TMS_CFG_ADDR, 8'h07);
      chk("int clear bit", 8'h00, {7'h00, int_out});
      wr(`TMS_CFG_ADDR, 8'h01);
      chk("int disabled", 8'h00, {7'h00, int_out});
      // stop, then clear the low status byte while nothing converts
      stopping = 1'b1;
      wr(`TMS_CFG_ADDR, 8'h02);
      rd_chk("sequencer idle", `TMS_SEQ_ADDR, 8'h00);
      wr(`TMS_STAT_ADDR, 8'hFF);
      rd_chk("status cleared", `TMS_STAT_ADDR, 8'h00);
      chk("int after clear", 8'h00, {7'h00, int_out});
      stopping = 1'b0;
      // hot alarm still held: remote one must not flag again
      wr(`TMS_CFG_ADDR, 8'h03);
      run_cycle();
      rd_chk("status again", `TMS_STAT_ADDR, 8'h28);
      chk("int again", 8'h01, {7'h00, int_out});
      // shared pair as two analog inputs; its diode reading is dropped
      wr(`TMS_CFG_ADDR, 8'h0B);
      chk("pair analog mode", 8'h00, {7'h00, pair_diode_mode_out});
      run_cycle();
      rd_chk("pair input a", `TMS_PAIR_A_ADDR, 8'h2F);
      rd_chk("pair input b", `TMS_PAIR_B_ADDR, 8'h30);
      rd_chk("dropped diode", 8'h81, 8'h19);
      rd_chk("local kept", `TMS_LOCAL_ADDR, 8'h9C);
      conclude();
   end
endmodule : test_tms_sequencer

/* File: tb/tms_adc_model.sv */
// converter front end model: one code per channel, changing mid-group
// assumes the sequencer's channel, busy and pair mode on the same clock
`timescale 1ns/1ps
module tms_adc_model #(
   parameter int TICK_CYCLES = 4
) (
   // clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       reset_n_in,
   // from the sequencer
   input  wire logic [4:0] adc_chan_out,
   input  wire logic       adc_busy_out,
   input  wire logic       pair_diode_mode_out,
   // converter result
   output logic      [7:0] adc_data_in
);
   int         run_cnt;
   int         win;
   logic [7:0] base;

   // ---------------------------------------------------------------
   // channel codes
   // ---------------------------------------------------------------
   // the shared pair answers as diode and as analog inputs alike
   always_comb begin
      case (adc_chan_out)
         5'h00:   base = 8'hE7;
         5'h01:   base = pair_diode_mode_out ? 8'h19 : 8'h77;
         5'h13:   base = 8'h9C;
         5'h14:   base = 8'h55;
         default: base = 8'h20 + {3'h0, adc_chan_out};
      endcase
   end

   // length of one conversion window in clocks
   assign win = ((adc_chan_out < 5'h02) ? 48 : 16) * TICK_CYCLES;

   // ---------------------------------------------------------------
   // result line
   // ---------------------------------------------------------------
   // second half of a group reads one code higher, so only a true
   // average of all sixteen lands on the base code; outside a
   // conversion the line toggles, as nothing valid is driven there
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         run_cnt     <= 0;
         adc_data_in <= 8'h00;
      end else if (adc_busy_out !== 1'b1) begin
         run_cnt     <= 0;
         adc_data_in <= ~adc_data_in;
      end else begin
         run_cnt     <= run_cnt + 1;
         adc_data_in <= base + ((run_cnt > win * 8 + win / 2) ? 8'h01 : 8'h00);
      end
   end
endmodule : tms_adc_model
